// [verilog/ufcx_pkg.sv]
package ufcx_pkg;

  // ****************************************
  // Register offsets on the serial register port
  // ****************************************
  localparam logic [7:0] ADDR_FORMAT_SEL = 8'h08;
  localparam logic [7:0] ADDR_CROSSPOINT = 8'h09;
  localparam logic [7:0] ADDR_PLL_FORCE = 8'h0A;
  localparam logic [7:0] ADDR_BOUND_HI_MSB = 8'h50;
  localparam logic [7:0] ADDR_BOUND_HI_LSB = 8'h52;
  localparam logic [7:0] ADDR_BOUND_LO_MSB = 8'h53;
  localparam logic [7:0] ADDR_BOUND_LO_LSB = 8'h54;
  localparam logic [7:0] ADDR_REF_DIV_HI = 8'h55;
  localparam logic [7:0] ADDR_REF_DIV_LO = 8'h56;
  localparam logic [7:0] ADDR_FB_DIV_HI = 8'h57;
  localparam logic [7:0] ADDR_FB_DIV_LO = 8'h58;
  localparam logic [7:0] ADDR_PUMP = 8'h59;
  localparam logic [7:0] ADDR_LPF_HI = 8'h5A;
  localparam logic [7:0] ADDR_LPF_LO = 8'h5B;
  localparam logic [7:0] ADDR_AFS = 8'h5C;
  localparam logic [7:0] ADDR_MISC = 8'h5D;
  localparam logic [7:0] ADDR_COUNT_MSB = 8'h5E;
  localparam logic [7:0] ADDR_COUNT_LSB = 8'h5F;
  localparam logic [7:0] ADDR_STATUS = 8'h60;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int MISC_EN_BIT = 7;
  localparam int MISC_ILACE_BIT = 4;
  localparam int MISC_RATE_MSB = 3;
  localparam int REF_DIV_HI_W = 2;
  localparam int FB_DIV_HI_W = 7;
  localparam int LPF_HI_W = 5;
  localparam int FORMAT_SEL_W = 5;
  localparam int FORCE_HD_BIT = 0;
  localparam int FORCE_FRAC_BIT = 1;
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_ILACE_BIT = 2;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CROSSPOINT = 4'h0;
  localparam logic [FORMAT_SEL_W-1:0] RST_FORMAT_SEL = 5'h00;
  localparam logic [FORMAT_SEL_W-1:0] USER_FORMAT_CODE = 5'h1F;
  localparam int MEAS_PERIODS = 20;
  localparam int MEAS_CNT_W = 16;

  typedef enum logic [1:0] {
    SRC_VCXO = 2'b00,
    SRC_HD = 2'b01,
    SRC_HD_FRAC = 2'b10
  } ufcx_src_t;

  typedef enum logic [3:0] {
    RATE_23_98 = 4'b0000,
    RATE_24 = 4'b0001,
    RATE_25 = 4'b0010,
    RATE_29_97 = 4'b0011,
    RATE_30 = 4'b0100,
    RATE_50 = 4'b0101,
    RATE_59_94 = 4'b0110,
    RATE_60 = 4'b0111
  } ufcx_rate_t;

  typedef enum logic [3:0] {
    XP_HD_FRAC = 4'b0000,
    XP_VCXO_VCXO = 4'b0001,
    XP_HD_HD = 4'b0010,
    XP_FRAC_FRAC = 4'b0011,
    XP_FRAC_HD = 4'b0100,
    XP_VCXO_FRAC = 4'b0101,
    XP_HD_VCXO = 4'b0110,
    XP_VCXO_HD = 4'b0111,
    XP_FRAC_VCXO = 4'b1000
  } ufcx_xp_t;

  // Returns {hdOff, fracOff, srcA, srcB}; reserved codes fall back to the default routing
  function automatic logic [5:0] xp_decode(input logic [3:0] code);
    logic [5:0] r;
    r = {1'b0, 1'b0, SRC_HD, SRC_HD_FRAC};
    case (code)
      XP_HD_FRAC: r = {1'b0, 1'b0, SRC_HD, SRC_HD_FRAC};
      XP_VCXO_VCXO: r = {1'b1, 1'b1, SRC_VCXO, SRC_VCXO};
      XP_HD_HD: r = {1'b0, 1'b1, SRC_HD, SRC_HD};
      XP_FRAC_FRAC: r = {1'b1, 1'b0, SRC_HD_FRAC, SRC_HD_FRAC};
      XP_FRAC_HD: r = {1'b0, 1'b0, SRC_HD_FRAC, SRC_HD};
      XP_VCXO_FRAC: r = {1'b1, 1'b0, SRC_VCXO, SRC_HD_FRAC};
      XP_HD_VCXO: r = {1'b0, 1'b1, SRC_HD, SRC_VCXO};
      XP_VCXO_HD: r = {1'b0, 1'b1, SRC_VCXO, SRC_HD};
      XP_FRAC_VCXO: r = {1'b1, 1'b0, SRC_HD_FRAC, SRC_VCXO};
      default: r = {1'b0, 1'b0, SRC_HD, SRC_HD_FRAC};
    endcase
    return r;
  endfunction

endpackage

// [verilog/ufcx_hsync_meter.sv]
`timescale 1ns/1ps
module ufcx_hsync_meter
  import ufcx_pkg::*;
#(
  parameter int CNT_W = MEAS_CNT_W,
  parameter int PERIODS = MEAS_PERIODS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsyncPin,
  input wire logic interlacePin,
  output logic [CNT_W-1:0] measCount,
  output logic measDone,
  output logic interlaceObs
);

  if (PERIODS < 2 || PERIODS > 255 || CNT_W < 8)
  begin : g_chk
    $error("ufcx_hsync_meter: unsupported PERIODS or CNT_W");
  end

  localparam logic [7:0] PER_LAST = 8'(PERIODS - 1);

  typedef enum logic [0:0] {
    MS_WAIT = 1'b0,
    MS_COUNT = 1'b1
  } ufcx_meas_st_t;

  typedef struct packed {
    logic [2:0] hsSync;
    logic [2:0] ilSync;
    logic hsStable;
    logic ilStable;
    ufcx_meas_st_t st;
    logic [7:0] periods;
    logic [CNT_W-1:0] cycles;
    logic [CNT_W-1:0] count;
    logic done;
  } ufcx_meter_t;

  ufcx_meter_t s_q;
  ufcx_meter_t s_d;

  always_comb
  begin
    logic hsRise;
    hsRise = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.hsSync = {s_q.hsSync[1:0], hsyncPin};
    s_d.ilSync = {s_q.ilSync[1:0], interlacePin};
    // Only the second and third stages decide; the first may be metastable
    if (s_q.hsSync[1] == s_q.hsSync[2])
    begin
      s_d.hsStable = s_q.hsSync[2];
    end
    if (s_q.ilSync[1] == s_q.ilSync[2])
    begin
      s_d.ilStable = s_q.ilSync[2];
    end
    hsRise = s_d.hsStable && !s_q.hsStable;
    case (s_q.st)
      MS_WAIT:
      begin
        if (hsRise)
        begin
          s_d.st = MS_COUNT;
          s_d.cycles = '0;
          s_d.periods = '0;
        end
      end
      MS_COUNT:
      begin
        if (s_q.cycles != '1)
        begin
          s_d.cycles = s_q.cycles + CNT_W'(1);
        end
        if (hsRise)
        begin
          if (s_q.periods == PER_LAST)
          begin
            s_d.count = s_d.cycles;
            s_d.done = 1'b1;
            s_d.cycles = '0;
            s_d.periods = '0;
          end
          else
          begin
            s_d.periods = s_q.periods + 8'h01;
          end
        end
      end
      default: s_d.st = MS_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign measCount = s_q.count;
  assign measDone = s_q.done;
  assign interlaceObs = s_q.ilStable;

  property p_meas_window;
    @(posedge clk_sys) disable iff (rst)
    s_q.done |-> $past(s_q.periods) == PER_LAST && s_q.periods == 8'h00;
  endproperty
  a_meas_window: assert property (p_meas_window) else $error("measurement closed on wrong period");

endmodule

// [verilog/user_format_and_clock_crosspoint.sv]
`timescale 1ns/1ps
// Overview of operation
// - User format detected only when enable set
// - User code selects stored interlace flag out
// - Detection needs observed interlace equal flag
// - User code selects stored frame-rate code out
// - Crosspoint code picks both clock output sources
// - Crosspoint code implies loop disable states
// - Force registers turn loops off independently
// - Frame-rate codes use fixed binary encoding
// - Count cycles across twenty hsync periods
// - Compare count with programmed min, max
module user_format_and_clock_crosspoint
  import ufcx_pkg::*;
#(
  parameter int PERIODS = MEAS_PERIODS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic hsyncPin,
  input wire logic interlacePin,
  input wire logic presetInterlace,
  input wire logic [3:0] presetFrameRate,
  output logic [1:0] clockOutputASrc,
  output logic [1:0] clockOutputBSrc,
  output logic hdPllOff,
  output logic hdPllFracOff,
  output logic interlaceIndicator,
  output logic [3:0] inputFrameRateCode,
  output logic userFormatMatch,
  output logic [9:0] userRefDivider,
  output logic [14:0] userFeedbackDivider,
  output logic [7:0] userPumpCurrent,
  output logic [12:0] userLinesPerFrame,
  output logic [7:0] userAudioFrameSetting
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [FORMAT_SEL_W-1:0] formatSel;
    logic [3:0] crosspoint;
    logic [1:0] forceOff;
    logic [15:0] boundHi;
    logic [15:0] boundLo;
    logic [REF_DIV_HI_W-1:0] refDivHi;
    logic [7:0] refDivLo;
    logic [FB_DIV_HI_W-1:0] fbDivHi;
    logic [7:0] fbDivLo;
    logic [7:0] pump;
    logic [LPF_HI_W-1:0] lpfHi;
    logic [7:0] lpfLo;
    logic [7:0] afs;
    logic userEn;
    logic userIlace;
    logic [3:0] userRate;
    logic match;
    logic measValid;
    logic [15:0] lastCount;
    logic [7:0] rdData;
    logic [1:0] srcA;
    logic [1:0] srcB;
    logic offHd;
    logic offFrac;
    logic ilaceOut;
    logic [3:0] rateOut;
  } ufcx_state_t;

  ufcx_state_t s_q;
  ufcx_state_t s_d;

  logic [MEAS_CNT_W-1:0] measCount;
  logic measDone;
  logic interlaceObs;

  ufcx_hsync_meter #(
    .CNT_W(MEAS_CNT_W),
    .PERIODS(PERIODS)
  ) u_meter (
    .clk_sys(clk_sys),
    .rst(rst),
    .hsyncPin(hsyncPin),
    .interlacePin(interlacePin),
    .measCount(measCount),
    .measDone(measDone),
    .interlaceObs(interlaceObs)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [5:0] xp;
    logic inRange;
    xp = '0;
    inRange = 1'b0;
    s_d = s_q;
    if (regWrEn)
    begin
      case (regAddr)
        ADDR_FORMAT_SEL: s_d.formatSel = regWrData[FORMAT_SEL_W-1:0];
        ADDR_CROSSPOINT: s_d.crosspoint = regWrData[3:0];
        ADDR_PLL_FORCE: s_d.forceOff = regWrData[1:0];
        ADDR_BOUND_HI_MSB: s_d.boundHi[15:8] = regWrData;
        ADDR_BOUND_HI_LSB: s_d.boundHi[7:0] = regWrData;
        ADDR_BOUND_LO_MSB: s_d.boundLo[15:8] = regWrData;
        ADDR_BOUND_LO_LSB: s_d.boundLo[7:0] = regWrData;
        ADDR_REF_DIV_HI: s_d.refDivHi = regWrData[REF_DIV_HI_W-1:0];
        ADDR_REF_DIV_LO: s_d.refDivLo = regWrData;
        ADDR_FB_DIV_HI: s_d.fbDivHi = regWrData[FB_DIV_HI_W-1:0];
        ADDR_FB_DIV_LO: s_d.fbDivLo = regWrData;
        ADDR_PUMP: s_d.pump = regWrData;
        ADDR_LPF_HI: s_d.lpfHi = regWrData[LPF_HI_W-1:0];
        ADDR_LPF_LO: s_d.lpfLo = regWrData;
        ADDR_AFS: s_d.afs = regWrData;
        ADDR_MISC:
        begin
          s_d.userEn = regWrData[MISC_EN_BIT];
          s_d.userIlace = regWrData[MISC_ILACE_BIT];
          s_d.userRate = regWrData[MISC_RATE_MSB:0];
        end
        default: s_d.rdData = s_q.rdData;
      endcase
    end

    inRange = (measCount >= s_q.boundLo) && (measCount <= s_q.boundHi);
    if (measDone)
    begin
      s_d.lastCount = measCount;
      s_d.measValid = 1'b1;
      s_d.match = s_q.userEn && inRange && (interlaceObs == s_q.userIlace);
    end
    s_d.match = s_d.match && s_d.userEn;

    xp = xp_decode(s_d.crosspoint);
    s_d.srcA = xp[3:2];
    s_d.srcB = xp[1:0];
    s_d.offHd = xp[5] | s_d.forceOff[FORCE_HD_BIT];
    s_d.offFrac = xp[4] | s_d.forceOff[FORCE_FRAC_BIT];

    if (s_d.formatSel == USER_FORMAT_CODE)
    begin
      s_d.ilaceOut = s_d.userIlace;
      s_d.rateOut = s_d.userRate;
    end
    else
    begin
      s_d.ilaceOut = presetInterlace;
      s_d.rateOut = presetFrameRate;
    end

    // Read data is registered: one cycle after the address
    case (regAddr)
      ADDR_FORMAT_SEL: s_d.rdData = {3'h0, s_q.formatSel};
      ADDR_CROSSPOINT: s_d.rdData = {4'h0, s_q.crosspoint};
      ADDR_PLL_FORCE: s_d.rdData = {6'h00, s_q.forceOff};
      ADDR_BOUND_HI_MSB: s_d.rdData = s_q.boundHi[15:8];
      ADDR_BOUND_HI_LSB: s_d.rdData = s_q.boundHi[7:0];
      ADDR_BOUND_LO_MSB: s_d.rdData = s_q.boundLo[15:8];
      ADDR_BOUND_LO_LSB: s_d.rdData = s_q.boundLo[7:0];
      ADDR_REF_DIV_HI: s_d.rdData = {6'h00, s_q.refDivHi};
      ADDR_REF_DIV_LO: s_d.rdData = s_q.refDivLo;
      ADDR_FB_DIV_HI: s_d.rdData = {1'b0, s_q.fbDivHi};
      ADDR_FB_DIV_LO: s_d.rdData = s_q.fbDivLo;
      ADDR_PUMP: s_d.rdData = s_q.pump;
      ADDR_LPF_HI: s_d.rdData = {3'h0, s_q.lpfHi};
      ADDR_LPF_LO: s_d.rdData = s_q.lpfLo;
      ADDR_AFS: s_d.rdData = s_q.afs;
      ADDR_MISC: s_d.rdData = {s_q.userEn, 2'h0, s_q.userIlace, s_q.userRate};
      ADDR_COUNT_MSB: s_d.rdData = s_q.lastCount[15:8];
      ADDR_COUNT_LSB: s_d.rdData = s_q.lastCount[7:0];
      ADDR_STATUS: s_d.rdData = {5'h00, interlaceObs, s_q.measValid, s_q.match};
      default: s_d.rdData = RST_BYTE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.formatSel <= RST_FORMAT_SEL;
      s_q.crosspoint <= RST_CROSSPOINT;
      s_q.srcA <= SRC_HD;
      s_q.srcB <= SRC_HD_FRAC;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign clockOutputASrc = s_q.srcA;
  assign clockOutputBSrc = s_q.srcB;
  assign hdPllOff = s_q.offHd;
  assign hdPllFracOff = s_q.offFrac;
  assign interlaceIndicator = s_q.ilaceOut;
  assign inputFrameRateCode = s_q.rateOut;
  assign userFormatMatch = s_q.match;
  assign userRefDivider = {s_q.refDivHi, s_q.refDivLo};
  assign userFeedbackDivider = {s_q.fbDivHi, s_q.fbDivLo};
  assign userPumpCurrent = s_q.pump;
  assign userLinesPerFrame = {s_q.lpfHi, s_q.lpfLo};
  assign userAudioFrameSetting = s_q.afs;

  // ****************************************
  // Assertions
  // ****************************************
  property p_enable_gate;
    @(posedge clk_sys) disable iff (rst)
    !s_q.userEn |-> !userFormatMatch;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("match while user format disabled");

  property p_user_ilace;
    @(posedge clk_sys) disable iff (rst)
    regWrEn && regAddr == ADDR_MISC ##1 s_q.formatSel == USER_FORMAT_CODE
      |-> interlaceIndicator == $past(regWrData[MISC_ILACE_BIT]);
  endproperty
  a_user_ilace: assert property (p_user_ilace) else $error("interlace indicator not user flag");

  property p_ilace_mismatch;
    @(posedge clk_sys) disable iff (rst)
    measDone && interlaceObs != s_q.userIlace |=> !userFormatMatch;
  endproperty
  a_ilace_mismatch: assert property (p_ilace_mismatch) else $error("match with interlace mismatch");

  property p_user_rate;
    @(posedge clk_sys) disable iff (rst)
    s_q.formatSel == USER_FORMAT_CODE |-> inputFrameRateCode == s_q.userRate;
  endproperty
  a_user_rate: assert property (p_user_rate) else $error("frame rate code not user code");

  property p_route;
    @(posedge clk_sys) disable iff (rst)
    s_q.crosspoint == XP_VCXO_FRAC |-> clockOutputASrc == SRC_VCXO && clockOutputBSrc == SRC_HD_FRAC;
  endproperty
  a_route: assert property (p_route) else $error("wrong routing for code 0101");

  property p_implied_off;
    @(posedge clk_sys) disable iff (rst)
    s_q.crosspoint == XP_HD_HD && s_q.forceOff == 2'h0 |-> !hdPllOff && hdPllFracOff;
  endproperty
  a_implied_off: assert property (p_implied_off) else $error("wrong loop disables for code 0010");

  property p_force;
    @(posedge clk_sys) disable iff (rst)
    regWrEn && regAddr == ADDR_PLL_FORCE && regWrData[FORCE_FRAC_BIT] |=> hdPllFracOff;
  endproperty
  a_force: assert property (p_force) else $error("forced disable not applied");

  property p_above_max;
    @(posedge clk_sys) disable iff (rst)
    measDone && measCount > s_q.boundHi |=> !userFormatMatch;
  endproperty
  a_above_max: assert property (p_above_max) else $error("match above maximum bound");

  property p_match;
    @(posedge clk_sys) disable iff (rst)
    measDone && !regWrEn && s_q.userEn && interlaceObs == s_q.userIlace
      && measCount >= s_q.boundLo && measCount <= s_q.boundHi |=> userFormatMatch;
  endproperty
  a_match: assert property (p_match) else $error("valid user format not matched");

endmodule

// [bench/ufcx_host.sv]
`timescale 1ns/1ps
// ****************************************
// Host model on the register port
// ****************************************
module ufcx_host
(
  input wire logic clk_sys,
  output logic regWrEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial
  begin
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // Host avoids reserved
  // Callers only pass crosspoint codes 0 to 8; reserved codes fall back to the default routing of code 0
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // Read data is registered, so it settles one edge after the address is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    d = regRdData;
  endtask
endmodule

// [bench/user_format_and_clock_crosspoint_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t mismatch got %h exp %h", $time, g, e); end end
module user_format_and_clock_crosspoint_tb
  import ufcx_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic regWrEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic hsyncPin = 1'b0;
  logic interlacePin = 1'b1;
  logic presetInterlace = 1'b0;
  logic [3:0] presetFrameRate = 4'h6;
  logic [1:0] clockOutputASrc;
  logic [1:0] clockOutputBSrc;
  logic hdPllOff;
  logic hdPllFracOff;
  logic interlaceIndicator;
  logic [3:0] inputFrameRateCode;
  logic userFormatMatch;
  logic [9:0] userRefDivider;
  logic [14:0] userFeedbackDivider;
  logic [7:0] userPumpCurrent;
  logic [12:0] userLinesPerFrame;
  logic [7:0] userAudioFrameSetting;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [5:0] xpTable [0:8] = '{6'h06, 6'h30, 6'h15, 6'h2A, 6'h09, 6'h22, 6'h14, 6'h11, 6'h28};
  logic [7:0] rwMask [0:8] = '{8'h03, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h9F};

  always #50 clk_sys = ~clk_sys;

  // Reference hsync with a period of 20 clocks
  always
  begin
    repeat (10) @(posedge clk_sys);
    hsyncPin <= ~hsyncPin;
  end

  ufcx_host host (.clk_sys(clk_sys), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData));

  user_format_and_clock_crosspoint #(.PERIODS(2)) uut (.clk_sys(clk_sys), .rst(rst), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .hsyncPin(hsyncPin),
    .interlacePin(interlacePin), .presetInterlace(presetInterlace), .presetFrameRate(presetFrameRate),
    .clockOutputASrc(clockOutputASrc), .clockOutputBSrc(clockOutputBSrc), .hdPllOff(hdPllOff),
    .hdPllFracOff(hdPllFracOff), .interlaceIndicator(interlaceIndicator),
    .inputFrameRateCode(inputFrameRateCode), .userFormatMatch(userFormatMatch),
    .userRefDivider(userRefDivider), .userFeedbackDivider(userFeedbackDivider),
    .userPumpCurrent(userPumpCurrent), .userLinesPerFrame(userLinesPerFrame),
    .userAudioFrameSetting(userAudioFrameSetting));

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Hang guard
  // ****************************************
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK({hdPllOff, hdPllFracOff, clockOutputASrc, clockOutputBSrc}, xpTable[0])
    `CHK({interlaceIndicator, inputFrameRateCode}, 5'h06)
    host.rd(8'h51, rv);
    `CHK(rv, 8'h00)
    // Reset values, then reserved bits of each user byte read back as zero
    for (int i = 0; i < 9; i++)
    begin
      host.rd(ADDR_REF_DIV_HI + i[7:0], rv);
      `CHK(rv, 8'h00)
      host.wr(ADDR_REF_DIV_HI + i[7:0], 8'hFF);
      host.rd(ADDR_REF_DIV_HI + i[7:0], rv);
      `CHK(rv, rwMask[i])
    end
    `CHK({userRefDivider, userFeedbackDivider, userLinesPerFrame}, {10'h3FF, 15'h7FFF, 13'h1FFF})
    `CHK({userPumpCurrent, userAudioFrameSetting}, 16'hFFFF)
    for (int i = 0; i < 9; i++)
    begin
      host.wr(ADDR_CROSSPOINT, i[7:0]);
      `CHK({hdPllOff, hdPllFracOff, clockOutputASrc, clockOutputBSrc}, xpTable[i])
    end
    // force adds loop disables on top of the code; it never turns a loop back on
    host.wr(ADDR_CROSSPOINT, 8'h00);
    host.wr(ADDR_PLL_FORCE, 8'h03);
    `CHK({hdPllOff, hdPllFracOff, clockOutputASrc, clockOutputBSrc}, 6'h36)
    host.wr(ADDR_CROSSPOINT, 8'h02);
    host.wr(ADDR_PLL_FORCE, 8'h01);
    `CHK({hdPllOff, hdPllFracOff}, 2'b11)
    host.wr(ADDR_PLL_FORCE, 8'h00);
    `CHK({hdPllOff, hdPllFracOff}, 2'b01)
    // user code feeds the stored flag and rate
    host.wr(ADDR_FORMAT_SEL, 8'(USER_FORMAT_CODE));
    for (int i = 0; i < 8; i++)
    begin
      host.wr(ADDR_MISC, 8'h10 | i[7:0]);
      `CHK({interlaceIndicator, inputFrameRateCode}, {1'b1, i[3:0]})
    end
    `CHK(RATE_60, 4'h7)
    host.wr(ADDR_MISC, 8'h05);
    `CHK({interlaceIndicator, inputFrameRateCode}, 5'h05)
    // Leaving the user code hands the lookup back to the preset values
    host.wr(ADDR_FORMAT_SEL, 8'h00);
    `CHK({interlaceIndicator, inputFrameRateCode}, 5'h06)
    host.wr(ADDR_FORMAT_SEL, 8'(USER_FORMAT_CODE));
    // Two periods of 20 clocks give a count near 40
    host.wr(ADDR_BOUND_HI_MSB, 8'h00);
    host.wr(ADDR_BOUND_HI_LSB, 8'h32);
    host.wr(ADDR_BOUND_LO_MSB, 8'h00);
    host.wr(ADDR_BOUND_LO_LSB, 8'h1E);
    host.wr(ADDR_MISC, 8'h90);
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(userFormatMatch, 1'b1)
    host.rd(ADDR_COUNT_LSB, rv);
    `CHK(rv >= 8'h26 && rv <= 8'h2A, 1'b1)
    host.rd(ADDR_STATUS, rv);
    `CHK(rv[2:0], 3'b111)
    host.wr(ADDR_MISC, 8'h80);
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(userFormatMatch, 1'b0)
    host.wr(ADDR_MISC, 8'h90);
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(userFormatMatch, 1'b1)
    host.wr(ADDR_MISC, 8'h10);
    `CHK(userFormatMatch, 1'b0)
    host.wr(ADDR_MISC, 8'h90);
    host.wr(ADDR_BOUND_LO_LSB, 8'h2D);
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(userFormatMatch, 1'b0)
    host.wr(ADDR_BOUND_LO_LSB, 8'h1E);
    host.wr(ADDR_BOUND_HI_LSB, 8'h20);
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(userFormatMatch, 1'b0)
    // Both bounds equal to the exact count of two 20-clock periods: inclusive edges
    host.wr(ADDR_BOUND_HI_LSB, 8'h28);
    host.wr(ADDR_BOUND_LO_LSB, 8'h28);
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(userFormatMatch, 1'b1)
    print_verdict();
  end
endmodule
